// *** test/cit_cycle_timing_monitor.sv ***
// Timing checker for the instruction cycle sequencer
`timescale 1ns/1ns
`default_nettype none

module cit_cycle_timing_monitor #(
	parameter int CYC_W = 5,
	parameter int COUNT_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire cit_pkg::cit_class_t issue_class,
	input wire logic [8:0] issue_reglist,
	input wire logic issue_cond_met,
	input wire logic [CYC_W-1:0] call_cycles,
	input wire logic busy,
	input wire logic retire,
	input wire cit_pkg::cit_class_t retire_class,
	input wire logic [CYC_W-1:0] retire_cycles,
	input wire logic [COUNT_W-1:0] retire_count
);
	import cit_pkg::*;
	logic take; // Instruction accepted
	logic [CYC_W-1:0] need; // Length of the offered one
	logic [CYC_W-1:0] age_reg, age_next; // Cycles since take
	logic [CYC_W-1:0] exp_reg, exp_next; // Length in flight

	////////////////////////////////////////////////////////////
	// Expected length; a separate count keeps it independent of the sequencer
	always_comb begin
		take = issue_valid && issue_ready && !sys_rst;
		case (issue_class)
			CIT_LOAD, CIT_STORE: need = CYC_W'(2);
			CIT_LOAD_MULTI, CIT_STORE_MULTI, CIT_POP: need = CYC_W'(1 + $countones(issue_reglist[7:0]));
			CIT_PUSH: need = CYC_W'(1 + $countones(issue_reglist));
			CIT_POP_PC: need = CYC_W'(4 + $countones(issue_reglist));
			CIT_BRANCH_COND: need = issue_cond_met ? CYC_W'(3) : CYC_W'(1);
			CIT_BRANCH, CIT_WRITE_PC, CIT_BRANCH_TO_REG: need = CYC_W'(3);
			CIT_BRANCH_LINK, CIT_SPECIAL_REG: need = CYC_W'(4);
			CIT_SUPERVISOR_CALL: need = (call_cycles == '0) ? CYC_W'(1) : call_cycles;
			default: need = CYC_W'(1);
		endcase
		age_next = (sys_rst || (!take && retire)) ? '0 : take ? CYC_W'(1) : age_reg + (age_reg != '0);
		exp_next = sys_rst ? '0 : take ? need : exp_reg;
	end

	// Helper registers
	always_ff @(posedge clk) begin
		age_reg <= age_next;
		exp_reg <= exp_next;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_shift_one: assert property (
		take && issue_class inside {CIT_SHIFT_IMM, CIT_SHIFT_REG, CIT_ROTATE_REG} |=> retire && retire_cycles == 1)
		else $error("shift not one cycle");
	a_addr_one: assert property (
		take && issue_class inside {CIT_ADDR_SP, CIT_ADDR_PC} |=> retire && retire_class == $past(issue_class))
		else $error("address forming not one cycle");
	a_ext_one: assert property (
		take && issue_class inside {CIT_EXTEND, CIT_REVERSE} |=> retire && retire_cycles == 1)
		else $error("extend or reverse not one cycle");
	a_mem_two: assert property (
		take && issue_class inside {CIT_LOAD, CIT_STORE} |=> busy && !retire ##1 retire && retire_cycles == 2)
		else $error("load or store not two cycles");
	a_branch_reg: assert property (
		take && issue_class == CIT_BRANCH_TO_REG |=> (busy && !retire)[*2] ##1 retire && retire_cycles == 3)
		else $error("register branch not three cycles");
	a_cond_taken: assert property (
		take && issue_class == CIT_BRANCH_COND && issue_cond_met |-> ##3 retire && retire_cycles == 3)
		else $error("taken branch not three cycles");
	a_multi_len: assert property (
		retire && retire_class inside {CIT_LOAD_MULTI, CIT_STORE_MULTI, CIT_PUSH, CIT_POP}
		|-> retire_cycles == exp_reg && age_reg == exp_reg)
		else $error("multiple transfer length wrong");
	a_pop_pc_len: assert property (
		retire && retire_class == CIT_POP_PC |-> retire_cycles == exp_reg && age_reg == exp_reg)
		else $error("pop with return length wrong");
	a_call_len: assert property (
		retire && retire_class == CIT_SUPERVISOR_CALL |-> retire_cycles == exp_reg && age_reg == exp_reg)
		else $error("supervisor call length wrong");
	a_no_stall: assert property (
		retire == (age_reg != '0 && age_reg == exp_reg))
		else $error("retire early or late");

	c_back_to_back: cover property (retire && take);
	c_refused: cover property (issue_valid && !issue_ready);
	c_long_pop: cover property (retire && retire_class == CIT_POP_PC && retire_cycles == 13);
endmodule

`default_nettype wire

// *** test/tb_cit_cycle_timing.sv ***
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ns
`default_nettype none

module tb_cit_cycle_timing;
	import cit_pkg::*;
	logic clk, sys_rst, issue_valid, issue_ready, issue_cond_met, busy, retire;
	cit_class_t issue_class, retire_class, m_cls, t_cls;
	logic [8:0] issue_reglist;
	logic [4:0] call_cycles, retire_cycles;
	logic [15:0] retire_count;
	logic [31:0] r; // Random source
	int mismatches, checks, k, age, c, t_c, cnt, m_cyc;
	bit inflight, took, rst_d, ret;

	cit_cycle_timing #(.CYC_W(5), .COUNT_W(16)) dut (.clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .issue_class(issue_class), .issue_reglist(issue_reglist),
		.issue_cond_met(issue_cond_met), .call_cycles(call_cycles), .busy(busy), .retire(retire),
		.retire_class(retire_class), .retire_cycles(retire_cycles), .retire_count(retire_count));

	////////////////////////////////////////////////////////////
	// Clock, 50 ns period
	initial clk = 1'b0;
	always #25 clk = ~clk;

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run();
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Shift register for stimulus
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Model length of one instruction
	function automatic int calc(int cls, int lst, int cond, int cl);
		int n = 0;
		for (int b = 0; b < 8; b++) n += (lst >> b) & 1;
		case (cls)
			CIT_LOAD, CIT_STORE: return 2;
			CIT_LOAD_MULTI, CIT_STORE_MULTI, CIT_POP: return 1 + n;
			CIT_PUSH: return 1 + n + ((lst >> 8) & 1);
			CIT_POP_PC: return 4 + n + ((lst >> 8) & 1);
			CIT_BRANCH_COND: return cond ? 3 : 1;
			CIT_BRANCH, CIT_WRITE_PC, CIT_BRANCH_TO_REG: return 3;
			CIT_BRANCH_LINK, CIT_SPECIAL_REG: return 4;
			CIT_SUPERVISOR_CALL: return (cl == 0) ? 1 : cl;
			default: return 1;
		endcase
	endfunction

	// Advance model one cycle and compare all outputs
	task automatic step();
		@(negedge clk);
		ret = 0;
		if (rst_d) begin
			inflight = 0;
			cnt = 0;
			m_cls = CIT_ALU;
			m_cyc = 0;
		end else if (took) begin
			inflight = 1;
			age = 0;
			c = t_c;
			m_cls = m_cls;
		end
		if (inflight) begin
			age++;
			if (age == c) begin
				ret = 1;
				inflight = 0;
				cnt = (cnt + 1) % 65536;
				m_cyc = c;
				m_cls = t_cls;
			end
		end
		check(retire, ret);
		check(busy, inflight);
		check(issue_ready, !inflight);
		check(retire_cycles, m_cyc);
		check(retire_class, m_cls);
		check(retire_count, cnt);
	endtask

	// Offer next instruction; random class while busy is refused
	task automatic drive();
		r = lfsr(r);
		issue_valid = r[0] | r[1];
		issue_class = cit_class_t'(!inflight ? k % 22 : r[12:8] % 22);
		issue_reglist = (k < 22) ? 9'h000 : (k < 44) ? 9'h1ff : r[24:16];
		issue_cond_met = r[2];
		call_cycles = (k < 22) ? 5'h00 : r[7:3];
		rst_d = sys_rst;
		took = issue_valid && !inflight && !sys_rst;
		if (took) begin
			t_cls = issue_class;
			t_c = calc(issue_class, issue_reglist, issue_cond_met, call_cycles);
		end
	endtask

	// Watchdog
	initial begin
		#1000000;
		mismatches++;
		complete_run();
	end

	// Main sequence
	initial begin
		r = 32'h00011a46;
		sys_rst = 1'b1;
		issue_valid = 1'b0;
		issue_class = CIT_ALU;
		issue_reglist = 9'h000;
		issue_cond_met = 1'b0;
		call_cycles = 5'h00;
		rst_d = 1;
		repeat (2) step();
		sys_rst = 1'b0;
		drive();
		while (k < 110) begin
			step();
			if (took) k++;
			// Index 60 is a three-cycle branch, so the model is mid-flight here
			sys_rst = (k == 61 && inflight && !rst_d) ? 1'b1 : 1'b0;
			drive();
		end
		complete_run();
	end
endmodule

bind cit_cycle_timing cit_cycle_timing_monitor #(.CYC_W(CYC_W), .COUNT_W(COUNT_W)) mon (.clk(clk),
	.sys_rst(sys_rst), .issue_valid(issue_valid), .issue_ready(issue_ready), .issue_class(issue_class),
	.issue_reglist(issue_reglist), .issue_cond_met(issue_cond_met), .call_cycles(call_cycles), .busy(busy),
	.retire(retire), .retire_class(retire_class), .retire_cycles(retire_cycles), .retire_count(retire_count));

`default_nettype wire

// *** verilog/cit_count_if.sv ***
// Transfer list and element count between the sequencer and the list counter
`timescale 1ns/1ns
`default_nettype none

interface cit_count_if;
	logic [8:0] reg_list; // One bit per transferred element
	logic [3:0] elem_count; // Number of set bits in reg_list

	// Sequencer side
	modport source (
		output reg_list,
		input elem_count
	);

	// Counter side
	modport counter (
		input reg_list,
		output elem_count
	);
endinterface

`default_nettype wire

// *** verilog/cit_cycle_timing.sv ***
// Instruction cycle timing sequencer of the core
//
// Behaviour
// - Immediate shifts take one cycle.
// - Register-amount shifts take one cycle.
// - Register rotate right takes one cycle.
// - Address from stack pointer: one cycle.
// - Address from program counter: one cycle.
// - Every single load takes two cycles.
// - Every single store takes two cycles.
// - Multiple load/store: one plus N cycles.
// - Push and plain pop: one plus N.
// - Branch to register takes three cycles.
// - Byte/halfword extension takes one cycle.
// - Every byte reversal takes one cycle.
// - N counts registers in the list.
// - Conditional branch: three taken, one not.
// - Pop with PC counts PC in N.
// - Supervisor call length set by configuration.
`timescale 1ns/1ns
`default_nettype none

`include "cit_regs.svh"

module cit_cycle_timing #(
	parameter int CYC_W = 5, // Width of cycle figures
	parameter int COUNT_W = 16 // Width of the retired-instruction counter
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire cit_pkg::cit_class_t issue_class,
	input wire logic [8:0] issue_reglist,
	input wire logic issue_cond_met,
	input wire logic [CYC_W-1:0] call_cycles,
	output logic busy,
	output logic retire,
	output cit_pkg::cit_class_t retire_class,
	output logic [CYC_W-1:0] retire_cycles,
	output logic [COUNT_W-1:0] retire_count
);
	import cit_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// Longest fixed figure is a pop with PC of a full list: 4 + 9 = 13
	if (CYC_W < 4) begin
		$error("CYC_W must be at least 4");
	end
	if (COUNT_W < 1) begin
		$error("COUNT_W must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	cit_state_t state_reg, state_next; // Sequencer state
	logic [CYC_W-1:0] remain_reg, remain_next; // Cycles still to run
	cit_class_t pend_class_reg, pend_class_next; // Class in flight
	logic [CYC_W-1:0] pend_cycles_reg, pend_cycles_next; // Its full length
	logic retire_reg, retire_next; // One-cycle completion pulse
	cit_class_t retire_class_reg, retire_class_next; // Class just finished
	logic [CYC_W-1:0] retire_cycles_reg, retire_cycles_next; // Its length
	logic [COUNT_W-1:0] count_reg, count_next; // Retired instructions
	logic [CYC_W-1:0] issue_cycles; // Length of the offered instruction
	logic extra_counts; // LR or PC element belongs in N
	logic [3:0] elem_n; // Registers in the transfer list

	cit_count_if list_if ();

	////////////////////////////////////////////////////////////////////////////
	// Transfer-list counting

	// Bit 8 is LR for a push and PC for a pop-and-return; other
	// classes only carry low registers, so the bit is dropped there
	always_comb begin
		extra_counts = (issue_class == CIT_PUSH) || (issue_class == CIT_POP_PC);
	end

	// List handed to the counter
	assign list_if.reg_list = {issue_reglist[`CIT_LIST_EXTRA_BIT] & extra_counts, issue_reglist[7:0]};
	assign elem_n = list_if.elem_count;

	// Shared bit counter
	cit_list_counter u_list_counter (
		.cnt_if(list_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// Cycle figure for one instruction

	// Widen a four-bit figure to the cycle width
	function automatic logic [CYC_W-1:0] widen(input logic [3:0] v);
		widen = CYC_W'(v);
	endfunction

	// Total occupancy; memory is taken as zero-wait with no contention
	function automatic logic [CYC_W-1:0] cycles_of(
		input cit_class_t cls,
		input logic [3:0] n,
		input logic cond,
		input logic [CYC_W-1:0] call_len
	);
		logic [CYC_W-1:0] c;
		c = widen(`CIT_CYC_ONE);
		case (cls)
			CIT_SHIFT_IMM: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_SHIFT_REG: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_ROTATE_REG: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_ADDR_SP: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_ADDR_PC: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_EXTEND: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_REVERSE: begin
				c = widen(`CIT_CYC_ONE);
			end
			CIT_LOAD: begin
				c = widen(`CIT_CYC_MEM);
			end
			CIT_STORE: begin
				c = widen(`CIT_CYC_MEM);
			end
			CIT_LOAD_MULTI, CIT_STORE_MULTI: begin
				c = widen(`CIT_CYC_MULTI_BASE) + widen(n);
			end
			CIT_PUSH, CIT_POP: begin
				c = widen(`CIT_CYC_MULTI_BASE) + widen(n);
			end
			CIT_POP_PC: begin
				c = widen(`CIT_CYC_POP_PC_BASE) + widen(n);
			end
			CIT_BRANCH_COND: begin
				// Untaken branch falls straight through
				c = cond ? widen(`CIT_CYC_BRANCH) : widen(`CIT_CYC_ONE);
			end
			CIT_BRANCH, CIT_WRITE_PC: begin
				c = widen(`CIT_CYC_BRANCH);
			end
			CIT_BRANCH_TO_REG: begin
				c = widen(`CIT_CYC_BRANCH);
			end
			CIT_BRANCH_LINK, CIT_SPECIAL_REG: begin
				c = widen(`CIT_CYC_LONG);
			end
			CIT_SUPERVISOR_CALL: begin
				// Zero would mean no slot at all, so it is raised to one
				c = (call_len == '0) ? widen(`CIT_CYC_ONE) : call_len;
			end
			default: begin
				c = widen(`CIT_CYC_ONE);
			end
		endcase
		cycles_of = c;
	endfunction

	// Figure for whatever is offered this cycle
	always_comb begin
		issue_cycles = cycles_of(issue_class, elem_n, issue_cond_met, call_cycles);
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer next state

	// The issue cycle is the first cycle of the instruction; the
	// sequencer then holds the core for the remaining cycles
	always_comb begin
		state_next = state_reg;
		remain_next = remain_reg;
		pend_class_next = pend_class_reg;
		pend_cycles_next = pend_cycles_reg;
		retire_next = 1'b0;
		retire_class_next = retire_class_reg;
		retire_cycles_next = retire_cycles_reg;
		count_next = count_reg;
		case (state_reg)
			CIT_IDLE: begin
				if (issue_valid) begin
					if (issue_cycles == widen(`CIT_CYC_ONE)) begin
						// Single-cycle: done at the end of the issue cycle
						retire_next = 1'b1;
						retire_class_next = issue_class;
						retire_cycles_next = issue_cycles;
						count_next = count_reg + COUNT_W'(1);
					end else begin
						// Multi-cycle: hold the core for the rest
						state_next = CIT_BUSY;
						remain_next = issue_cycles - widen(`CIT_CYC_ONE);
						pend_class_next = issue_class;
						pend_cycles_next = issue_cycles;
					end
				end
			end
			CIT_BUSY: begin
				if (remain_reg == widen(`CIT_CYC_ONE)) begin
					// Last occupied cycle: release and report
					state_next = CIT_IDLE;
					remain_next = '0;
					retire_next = 1'b1;
					retire_class_next = pend_class_reg;
					retire_cycles_next = pend_cycles_reg;
					count_next = count_reg + COUNT_W'(1);
				end else begin
					// No wait states are ever inserted here
					remain_next = remain_reg - widen(`CIT_CYC_ONE);
				end
			end
			default: begin
				state_next = CIT_IDLE;
				remain_next = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer registers

	// Synchronous reset; all state has a defined value
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= CIT_IDLE;
			remain_reg <= widen(`CIT_RST_REMAIN);
			pend_class_reg <= CIT_ALU;
			pend_cycles_reg <= widen(`CIT_RST_REMAIN);
			retire_reg <= 1'b0;
			retire_class_reg <= CIT_ALU;
			retire_cycles_reg <= widen(`CIT_RST_REMAIN);
			count_reg <= COUNT_W'(`CIT_RST_COUNT);
		end else begin
			state_reg <= state_next;
			remain_reg <= remain_next;
			pend_class_reg <= pend_class_next;
			pend_cycles_reg <= pend_cycles_next;
			retire_reg <= retire_next;
			retire_class_reg <= retire_class_next;
			retire_cycles_reg <= retire_cycles_next;
			count_reg <= count_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Ready is combinational so back-to-back issue loses no cycle
	assign issue_ready = (state_reg == CIT_IDLE);
	assign busy = (state_reg == CIT_BUSY);
	assign retire = retire_reg;
	assign retire_class = retire_class_reg;
	assign retire_cycles = retire_cycles_reg;
	assign retire_count = count_reg;

endmodule

`default_nettype wire

// *** verilog/cit_list_counter.sv ***
// Population count of a multiple-register transfer list
`timescale 1ns/1ns
`default_nettype none

`include "cit_regs.svh"

module cit_list_counter (
	cit_count_if.counter cnt_if
);
	import cit_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Each set bit is one transferred register, so N is the bit count
	always_comb begin
		cnt_if.elem_count = 4'h0;
		for (int i = 0; i < `CIT_LIST_W; i++) begin
			cnt_if.elem_count = cnt_if.elem_count + {3'h0, cnt_if.reg_list[i]};
		end
	end

endmodule

`default_nettype wire

// *** verilog/cit_pkg.sv ***
// Types shared by the instruction cycle timing block
`default_nettype none

package cit_pkg;

	// Instruction classes, grouped by how long they occupy the core
	typedef enum logic [4:0] {
		CIT_ALU,
		CIT_SHIFT_IMM,
		CIT_SHIFT_REG,
		CIT_ROTATE_REG,
		CIT_ADDR_SP,
		CIT_ADDR_PC,
		CIT_EXTEND,
		CIT_REVERSE,
		CIT_LOAD,
		CIT_STORE,
		CIT_LOAD_MULTI,
		CIT_STORE_MULTI,
		CIT_PUSH,
		CIT_POP,
		CIT_POP_PC,
		CIT_BRANCH_COND,
		CIT_BRANCH,
		CIT_BRANCH_LINK,
		CIT_BRANCH_TO_REG,
		CIT_WRITE_PC,
		CIT_SPECIAL_REG,
		CIT_SUPERVISOR_CALL
	} cit_class_t;

	// Sequencer states
	typedef enum logic {
		CIT_IDLE,
		CIT_BUSY
	} cit_state_t;

endpackage

`default_nettype wire

// *** verilog/cit_regs.svh ***
// Cycle figures and reset values for the instruction cycle timing block
`ifndef CIT_REGS_SVH
`define CIT_REGS_SVH

// Base occupancy figures, in core clock cycles
`define CIT_CYC_ONE 4'h1
`define CIT_CYC_MEM 4'h2
`define CIT_CYC_BRANCH 4'h3
`define CIT_CYC_LONG 4'h4
`define CIT_CYC_MULTI_BASE 4'h1
`define CIT_CYC_POP_PC_BASE 4'h4

// Position of the LR / PC element in the transfer list
`define CIT_LIST_EXTRA_BIT 8
`define CIT_LIST_W 9

// Reset values
`define CIT_RST_REMAIN 4'h0
`define CIT_RST_COUNT 16'h0000

`endif
